// ==== verilog/cswm_pkg.sv ====
// Constants and types for the selective-wake mode and status block
package cswm_pkg;
   localparam logic [2:0] CSWM_MODE_OFF0   = 3'h0;
   localparam logic [2:0] CSWM_MODE_WAKE   = 3'h1;
   localparam logic [2:0] CSWM_MODE_RXONLY = 3'h2;
   localparam logic [2:0] CSWM_MODE_NORM   = 3'h3;
   localparam logic [2:0] CSWM_MODE_OFF1   = 3'h4;
   localparam logic [2:0] CSWM_MODE_SWK    = 3'h5;
   localparam logic [2:0] CSWM_MODE_RXSWK  = 3'h6;
   localparam logic [2:0] CSWM_MODE_NSWK   = 3'h7;
   localparam int         CSWM_MODE_MSB    = 2;
   // Serial register addresses of the selective-wake configuration range
   localparam logic [6:0] CSWM_CFG_LO      = 7'h21;
   localparam logic [6:0] CSWM_CFG_HI      = 7'h33;
   localparam logic [6:0] CSWM_CTRL_ADDR   = 7'h21;
   // Own status/control register map
   localparam logic [6:0] CSWM_REG_MODE    = 7'h10;
   localparam logic [6:0] CSWM_REG_STAT    = 7'h11;
   localparam logic [6:0] CSWM_REG_CFG     = 7'h12;
   localparam int         CSWM_ST_ERR      = 0;
   localparam int         CSWM_ST_TO       = 1;
   localparam int         CSWM_ST_SIL      = 2;
   localparam int         CSWM_ST_SYNC     = 3;
   localparam int         CSWM_ST_ACT      = 4;
   localparam int         CSWM_CF_VALID    = 0;
   localparam int         CSWM_CF_TOMASK   = 1;
   localparam int         CSWM_CF_GLOBAL   = 2;
   localparam logic [7:0] CSWM_RST_ZERO    = 8'h00;
   typedef enum logic [1:0] {CSWM_SBC_NORMAL, CSWM_SBC_STOP, CSWM_SBC_SLEEP,
                             CSWM_SBC_RESTART} cswm_sbc_t;
endpackage : cswm_pkg

// ==== verilog/cswm_top.sv ====
// Selective-wake mode selection and status flags of the CAN transceiver
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
module cswm_top
   import cswm_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_srst,
   input  wire logic [6:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire cswm_sbc_t  i_sbc_mode,
   input  wire logic       i_det_frame,
   input  wire logic       i_det_pat2,
   input  wire logic       i_det_pat1,
   input  wire logic       i_silence_exp,
   input  wire logic       i_wake_pattern,
   input  wire logic       i_wake_frame,
   input  wire logic       i_cnt_overflow,
   input  wire logic       i_frame_ok,
   input  wire logic       i_proto_err,
   input  wire logic       i_restart_by_frame,
   output logic            o_swk_enabled,
   output logic            o_tx_enable,
   output logic            o_rx_enable,
   output logic            o_wake_capable,
   output logic            o_frame_detect_en,
   output logic            o_can_wake_irq,
   output logic            o_sleep_wake,
   output logic            o_interrupt_out_n
);
   ////////////////////////////////////////////////////////////////////////
   logic [2:0] mode, next_mode;
   logic       err, next_err;
   logic       valid, next_valid;
   logic       to_flag, next_to_flag;
   logic       sil, next_sil;
   logic       sync, next_sync;
   logic       act, next_act;
   logic       to_mask, next_to_mask;
   logic       glob, next_glob;
   logic       irq, next_irq;
   logic       wake_irq, next_wake_irq;
   cswm_sbc_t  sbc_q;
   logic       in_normal, cfg_wr, mode_wr, swk_sel, restart_entry;
   logic       err_set, to_event, any_wake;

   // Decode of strobes against the live chip mode
   always_comb
   begin
      in_normal     = (i_sbc_mode == CSWM_SBC_NORMAL);
      cfg_wr        = i_wr && (i_addr >= CSWM_CFG_LO) && (i_addr <= CSWM_CFG_HI)
                      && (i_addr != CSWM_CTRL_ADDR);
      mode_wr       = i_wr && (i_addr == CSWM_REG_MODE) && in_normal;
      swk_sel       = mode[CSWM_MODE_MSB] && (mode != CSWM_MODE_OFF1);
      restart_entry = (i_sbc_mode == CSWM_SBC_RESTART) && (sbc_q != CSWM_SBC_RESTART);
      to_event      = (i_det_frame || i_det_pat2) && i_silence_exp;
      any_wake      = i_cnt_overflow || (i_det_pat2 && i_wake_pattern)
                      || (i_det_frame && i_wake_frame);
   end

   // Configuration, error and mode next state
   always_comb
   begin
      next_mode    = mode;
      next_valid   = valid;
      next_err     = err;
      next_to_mask = to_mask;
      next_glob    = glob;
      err_set      = 1'b0;
      if (i_wr && (i_addr == CSWM_REG_CFG))
      begin
         if (i_sbc_mode != CSWM_SBC_SLEEP)
         begin
            next_valid = i_wdata[CSWM_CF_VALID];
         end
         next_to_mask = i_wdata[CSWM_CF_TOMASK];
         next_glob    = i_wdata[CSWM_CF_GLOBAL];
      end
      // Sleep blocks config edits, Normal, Stop and Restart invalidate them
      if (cfg_wr && (i_sbc_mode != CSWM_SBC_SLEEP))
      begin
         next_valid = 1'b0;
         if (swk_sel)
         begin
            err_set = 1'b1;
         end
      end
      // Error clear refused while the check cannot pass
      if (i_wr && (i_addr == CSWM_REG_STAT) && i_wdata[CSWM_ST_ERR])
      begin
         if (!(mode[CSWM_MODE_MSB] && !next_valid))
         begin
            next_err = 1'b0;
         end
      end
      if (mode_wr)
      begin
         next_mode = i_wdata[2:0];
         if (i_wdata[CSWM_MODE_MSB] && (i_wdata[2:0] != CSWM_MODE_OFF1))
         begin
            if (next_valid)
            begin
               next_err = 1'b0;
            end
            else
            begin
               err_set = 1'b1;
            end
         end
      end
      if (restart_entry)
      begin
         next_valid = 1'b0;
         if (!i_restart_by_frame && swk_sel)
         begin
            err_set = 1'b1;
         end
      end
      if (i_cnt_overflow && swk_sel)
      begin
         err_set = 1'b1;
      end
      // Set beats a same-cycle clear
      if (err_set)
      begin
         next_err = 1'b1;
      end
   end

   // Status flag next state; hardware sets win over software clears
   always_comb
   begin
      next_to_flag  = to_flag;
      next_sil      = sil;
      next_sync     = sync;
      next_act      = act;
      next_wake_irq = 1'b0;
      if (i_wr && (i_addr == CSWM_REG_STAT) && i_wdata[CSWM_ST_TO])
      begin
         next_to_flag = 1'b0;
      end
      if (to_event)
      begin
         next_to_flag = 1'b1;
         next_sil     = 1'b1;
      end
      else if (i_wake_pattern)
      begin
         next_sil = 1'b0;
      end
      if (i_proto_err)
      begin
         next_sync = 1'b0;
      end
      else if (i_frame_ok && (o_rx_enable || i_det_frame))
      begin
         next_sync = 1'b1;
      end
      if (any_wake || !mode[CSWM_MODE_MSB])
      begin
         next_act = 1'b0;
      end
      else if ((o_swk_enabled && (i_det_frame || i_det_pat1)) || (err_set && i_det_pat2))
      begin
         next_act = 1'b1;
      end
      // Frame wake outside Sleep only flags the interrupt
      if (o_frame_detect_en && i_wake_frame && (i_sbc_mode != CSWM_SBC_SLEEP))
      begin
         next_wake_irq = 1'b1;
      end
      // Time-out fires per event regardless of the flag; Normal and Stop only
      next_irq = (to_mask && to_event && ((i_sbc_mode == CSWM_SBC_NORMAL)
                 || (i_sbc_mode == CSWM_SBC_STOP)))
                 || (glob && err_set);
   end

   // State registers
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         mode     <= CSWM_MODE_OFF0;
         err      <= 1'b0;
         valid    <= 1'b0;
         to_flag  <= 1'b0;
         sil      <= 1'b0;
         sync     <= 1'b0;
         act      <= 1'b0;
         to_mask  <= 1'b0;
         glob     <= 1'b0;
         irq      <= 1'b0;
         wake_irq <= 1'b0;
         sbc_q    <= CSWM_SBC_NORMAL;
      end
      else
      begin
         mode     <= next_mode;
         err      <= next_err;
         valid    <= next_valid;
         to_flag  <= next_to_flag;
         sil      <= next_sil;
         sync     <= next_sync;
         act      <= next_act;
         to_mask  <= next_to_mask;
         glob     <= next_glob;
         irq      <= next_irq;
         wake_irq <= next_wake_irq;
         sbc_q    <= i_sbc_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Effective transceiver behaviour; sync flag never gates wake entry
   always_comb
   begin
      o_swk_enabled     = swk_sel && !err;
      o_frame_detect_en = o_swk_enabled;
      o_sleep_wake      = o_frame_detect_en && i_wake_frame
                          && (i_sbc_mode == CSWM_SBC_SLEEP);
      o_can_wake_irq    = wake_irq;
      o_interrupt_out_n = !irq;
      o_tx_enable       = 1'b0;
      o_rx_enable       = 1'b0;
      o_wake_capable    = 1'b0;
      unique case (mode)
         CSWM_MODE_OFF0, CSWM_MODE_OFF1: ;
         CSWM_MODE_WAKE, CSWM_MODE_SWK: o_wake_capable = 1'b1;
         CSWM_MODE_RXONLY, CSWM_MODE_RXSWK: o_rx_enable = 1'b1;
         CSWM_MODE_NORM, CSWM_MODE_NSWK:
         begin
            o_rx_enable = 1'b1;
            o_tx_enable = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         o_rdata <= CSWM_RST_ZERO;
      end
      else if (i_rd && (i_addr == CSWM_REG_MODE))
      begin
         o_rdata <= {5'h0_0, mode};
      end
      else if (i_rd && (i_addr == CSWM_REG_STAT))
      begin
         o_rdata <= {3'h0, act, sync, sil, to_flag, err};
      end
      else if (i_rd && (i_addr == CSWM_REG_CFG))
      begin
         o_rdata <= {5'h0_0, glob, to_mask, valid};
      end
      else
      begin
         o_rdata <= CSWM_RST_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_ovf_swk;
      i_cnt_overflow && swk_sel;
   endsequence

   a_ovf_sets_err: assert property (@(posedge i_core_clk) disable iff (i_srst)
      s_ovf_swk |=> err) else $error("overflow did not set error");
   a_cfg_clears_val: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (cfg_wr && i_sbc_mode != CSWM_SBC_SLEEP) |=> !valid)
      else $error("config write kept valid");
   a_sleep_holds_val: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_sbc_mode == CSWM_SBC_SLEEP && !restart_entry) |=> valid == $past(valid))
      else $error("valid changed in sleep");
   a_mode_lock: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (!in_normal) |=> mode == $past(mode)) else $error("mode changed outside normal");
   a_to_sets: assert property (@(posedge i_core_clk) disable iff (i_srst)
      to_event |=> to_flag && sil) else $error("timeout flags not set");
   a_to_irq: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (to_mask && to_event && i_sbc_mode == CSWM_SBC_STOP) |=> !o_interrupt_out_n)
      else $error("timeout irq missing");
   a_sync_err: assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_proto_err |=> !sync) else $error("sync kept after error");
   a_act_clear: assert property (@(posedge i_core_clk) disable iff (i_srst)
      any_wake |=> !act) else $error("active flag kept after wake");
   a_err_no_swk: assert property (@(posedge i_core_clk) disable iff (i_srst)
      err |-> !o_swk_enabled) else $error("wake active with error");
   a_rx_no_tx: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (mode == CSWM_MODE_RXSWK) |-> (o_rx_enable && !o_tx_enable))
      else $error("receive-only transmits");

   ////////////////////////////////////////////////////////////////////////
   // Mode write that selects selective wake, split by the check outcome
   sequence s_pick_ok;
      mode_wr && i_wdata[CSWM_MODE_MSB] && (i_wdata[2:0] != CSWM_MODE_OFF1)
      && next_valid && !err_set;
   endsequence

   sequence s_pick_bad;
      mode_wr && i_wdata[CSWM_MODE_MSB] && (i_wdata[2:0] != CSWM_MODE_OFF1)
      && !next_valid;
   endsequence

   // Passing check enables wake with the error flag low
   a_check_pass: assert property (@(posedge i_core_clk) disable iff (i_srst)
      s_pick_ok |=> (!err && o_swk_enabled)) else $error("check pass ignored");
   // Failing check raises the error flag
   a_check_fail: assert property (@(posedge i_core_clk) disable iff (i_srst)
      s_pick_bad |=> err) else $error("check fail ignored");

   // Restart entry always drops the valid bit
   a_restart_val: assert property (@(posedge i_core_clk) disable iff (i_srst)
      restart_entry |=> !valid) else $error("valid kept over restart");
   // Restart not caused by a wake frame flags the error under a selective-wake mode
   a_restart_err: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (restart_entry && !i_restart_by_frame && swk_sel) |=> err)
      else $error("restart error missing");

   // Clear refused while the valid bit is low under a wake mode
   a_clr_refused: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_wr && (i_addr == CSWM_REG_STAT) && i_wdata[CSWM_ST_ERR] && mode[CSWM_MODE_MSB]
       && !next_valid && err) |=> err) else $error("error cleared without valid");

   // Control register edits leave the configuration valid
   a_ctrl_keeps: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_wr && (i_addr == CSWM_CTRL_ADDR) && valid && !restart_entry) |=> valid)
      else $error("control write dropped valid");

   // Time-out in Sleep stays silent; only an error set may interrupt there
   a_sleep_no_irq: assert property (@(posedge i_core_clk) disable iff (i_srst)
      ((i_sbc_mode == CSWM_SBC_SLEEP) && to_event && !(glob && err_set))
      |=> o_interrupt_out_n) else $error("timeout interrupt in sleep");

   // Wake pattern clears the silence flag unless silence expires with it
   a_sil_clear: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_wake_pattern && !to_event) |=> !sil) else $error("silence kept after pattern");

   // Clean frame on a receiving transceiver sets sync
   a_sync_set: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_frame_ok && !i_proto_err && o_rx_enable) |=> sync)
      else $error("sync not set by frame");

   // Clearing the mode MSB drops the active flag
   a_msb_act: assert property (@(posedge i_core_clk) disable iff (i_srst)
      !mode[CSWM_MODE_MSB] |=> !act) else $error("active flag kept without msb");

   // Both off codes leave the transceiver fully quiet
   a_off_quiet: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (mode[1:0] == 2'b00) |-> !(o_tx_enable || o_rx_enable || o_wake_capable))
      else $error("off mode not quiet");

   // Frame wake in Normal raises the wake interrupt one edge later
   a_wake_irq: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (o_frame_detect_en && i_wake_frame && in_normal) |=> o_can_wake_irq)
      else $error("wake interrupt missing");

   // Read data stand only after a read strobe
   a_rd_idle: assert property (@(posedge i_core_clk) disable iff (i_srst)
      !i_rd |=> (o_rdata == CSWM_RST_ZERO)) else $error("read data without strobe");
endmodule : cswm_top

// ==== tb/cswm_can_peer.sv ====
// Far-side CAN event source for the selective-wake bench
`timescale 1ns/10ps
module cswm_can_peer
(
   input  wire logic       i_core_clk,
   input  wire logic [2:0] i_ev,
   output logic      [5:0] o_pulse
);
   // Code n gives bit n-1 one cycle; the bus never repeats an event unasked
   always_ff @(posedge i_core_clk)
   begin
      for (int k = 0; k < 6; k++)
      begin
         o_pulse[k] <= (i_ev == 3'(k + 1));
      end
   end
endmodule : cswm_can_peer

// ==== tb/tb_top.sv ====
// Self-checking bench for the selective-wake mode and status block
`timescale 1ns/10ps
module tb_top;
   import cswm_pkg::*;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic [6:0] addr = 7'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   cswm_sbc_t  system_basis_chip = CSWM_SBC_NORMAL;
   logic       det = 1'b0;
   logic       by_frame = 1'b0;
   logic [2:0] ev = 3'h0;
   logic [5:0] pulse;
   logic       selective_wake, tx, rxe, wk, fde, cwi, slw, irq_n;
   int         miscompares = 0;
   int         tests_run = 0;
   ////////////////////////////////////////////////////////////////////////////
   always #2.5 clk = ~clk;
   // Pattern states 1 and 2 tied off; frame detection carries the flag tests
   cswm_top uut (.i_core_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sbc_mode(system_basis_chip), .i_det_frame(det),
      .i_det_pat2(1'b0), .i_det_pat1(1'b0), .i_silence_exp(pulse[0]),
      .i_wake_pattern(pulse[1]), .i_wake_frame(pulse[2]), .i_cnt_overflow(pulse[3]),
      .i_frame_ok(pulse[4]), .i_proto_err(pulse[5]), .i_restart_by_frame(by_frame),
      .o_swk_enabled(selective_wake), .o_tx_enable(tx), .o_rx_enable(rxe), .o_wake_capable(wk),
      .o_frame_detect_en(fde), .o_can_wake_irq(cwi), .o_sleep_wake(slw),
      .o_interrupt_out_n(irq_n));
   cswm_can_peer peer (.i_core_clk(clk), .i_ev(ev), .o_pulse(pulse));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Back-to-back writes let one idle edge pass so the strobe is set once
   task automatic wreg(input logic [6:0] a, input logic [7:0] d);
      if (wr)
      begin
         @(posedge clk);
      end
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   // Read data stand only in the cycle after the strobe
   task automatic rreg(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata & m, e);
      @(posedge clk);
   endtask : rreg
   // Pulsed outputs are caught over six cycles, so latency choice is free
   task automatic evw(input logic [2:0] c, input logic [2:0] e);
      logic [2:0] seen;
      seen = 3'h0;
      ev <= c;
      for (int n = 0; n < 6; n++)
      begin
         @(negedge clk);
         seen = seen | {slw, cwi, ~irq_n};
         @(posedge clk);
         if (n == 0)
         begin
            ev <= 3'h0;
         end
      end
      chk({5'h0, seen}, {5'h0, e});
   endtask : evw
   task automatic couts(input logic [2:0] m, input logic en);
      @(negedge clk);
      chk({2'h0, irq_n, selective_wake, tx, rxe, wk, fde},
          {2'h0, 1'b1, en, m[1:0] == 2'h3, m[1], m[1:0] == 2'h1, en});
      @(posedge clk);
   endtask : couts
   ////////////////////////////////////////////////////////////////////////////
   task automatic s_reset();
      rreg(CSWM_REG_STAT, 8'hff, 8'h00);
      rreg(CSWM_REG_MODE, 8'h07, 8'h00);
      couts(3'h0, 1'b0);
   endtask : s_reset
   task automatic s_decode();
      wreg(CSWM_REG_CFG, 8'h01);
      for (int m = 0; m < 8; m++)
      begin
         wreg(CSWM_REG_MODE, 8'(m));
         couts(3'(m), m >= 5);
         rreg(CSWM_REG_MODE, 8'h07, 8'(m));
      end
   endtask : s_decode
   task automatic s_cfg();
      wreg(CSWM_REG_CFG, 8'h05);
      wreg(CSWM_CTRL_ADDR, 8'h5a);
      couts(3'h7, 1'b1);
      wreg(CSWM_CFG_HI, 8'h5a);
      evw(3'h0, 3'h1);
      couts(3'h7, 1'b0);
      rreg(CSWM_REG_MODE, 8'h07, 8'h07);
      wreg(CSWM_REG_STAT, 8'h01);
      rreg(CSWM_REG_STAT, 8'h01, 8'h01);
      wreg(CSWM_REG_CFG, 8'h03);
      wreg(CSWM_REG_STAT, 8'h01);
      rreg(CSWM_REG_STAT, 8'h01, 8'h00);
   endtask : s_cfg
   task automatic s_timeout();
      det <= 1'b1;
      evw(3'h1, 3'h1);
      evw(3'h1, 3'h1);
      rreg(CSWM_REG_STAT, 8'hff, 8'h16);
      evw(3'h2, 3'h0);
      wreg(CSWM_REG_STAT, 8'h02);
      rreg(CSWM_REG_STAT, 8'hff, 8'h10);
   endtask : s_timeout
   task automatic s_sync();
      evw(3'h5, 3'h0);
      rreg(CSWM_REG_STAT, 8'h08, 8'h08);
      evw(3'h6, 3'h0);
      rreg(CSWM_REG_STAT, 8'h08, 8'h00);
   endtask : s_sync
   task automatic s_wake();
      // Frame wake seen in detection, then the woken transceiver leaves it
      ev <= 3'h3;
      @(posedge clk);
      ev <= 3'h0;
      @(posedge clk);
      det <= 1'b0;
      @(negedge clk);
      chk({5'h0, slw, cwi, ~irq_n}, 8'h02);
      @(posedge clk);
      couts(3'h7, 1'b1);
      rreg(CSWM_REG_STAT, 8'h10, 8'h00);
      det <= 1'b1;
      @(posedge clk);
      rreg(CSWM_REG_STAT, 8'h10, 8'h10);
      wreg(CSWM_REG_MODE, 8'h03);
      @(posedge clk);
      rreg(CSWM_REG_STAT, 8'h10, 8'h00);
   endtask : s_wake
   task automatic s_stop();
      wreg(CSWM_REG_MODE, 8'h07);
      system_basis_chip <= CSWM_SBC_STOP;
      wreg(CSWM_REG_MODE, 8'h03);
      rreg(CSWM_REG_MODE, 8'h07, 8'h07);
      couts(3'h7, 1'b1);
      evw(3'h1, 3'h1);
      wreg(7'h30, 8'h00);
      couts(3'h7, 1'b0);
      rreg(CSWM_REG_STAT, 8'h01, 8'h01);
   endtask : s_stop
   task automatic s_sleep();
      system_basis_chip <= CSWM_SBC_NORMAL;
      wreg(CSWM_REG_CFG, 8'h01);
      wreg(CSWM_REG_STAT, 8'h01);
      wreg(CSWM_REG_MODE, 8'h05);
      system_basis_chip <= CSWM_SBC_SLEEP;
      wreg(CSWM_CFG_HI, 8'h00);
      wreg(CSWM_REG_MODE, 8'h03);
      couts(3'h5, 1'b1);
      evw(3'h1, 3'h0);
      evw(3'h3, 3'h4);
   endtask : s_sleep
   // Restart by frame keeps the error clear; any other restart under a wake mode raises it
   task automatic s_restart();
      by_frame <= 1'b1;
      system_basis_chip <= CSWM_SBC_RESTART;
      evw(3'h0, 3'h0);
      rreg(CSWM_REG_STAT, 8'h01, 8'h00);
      system_basis_chip <= CSWM_SBC_NORMAL;
      wreg(CSWM_REG_CFG, 8'h01);
      wreg(CSWM_REG_MODE, 8'h07);
      by_frame <= 1'b0;
      system_basis_chip <= CSWM_SBC_RESTART;
      evw(3'h0, 3'h0);
      rreg(CSWM_REG_STAT, 8'h01, 8'h01);
      system_basis_chip <= CSWM_SBC_NORMAL;
      wreg(CSWM_REG_STAT, 8'h01);
      rreg(CSWM_REG_STAT, 8'h01, 8'h01);
      wreg(CSWM_REG_CFG, 8'h05);
      wreg(CSWM_REG_STAT, 8'h01);
      evw(3'h4, 3'h1);
      rreg(CSWM_REG_STAT, 8'h01, 8'h01);
   endtask : s_restart
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   // Every wait is a fixed, bounded count, so the sequence always ends here
   initial
   begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      s_reset();
      s_decode();
      s_cfg();
      s_timeout();
      s_sync();
      s_wake();
      s_stop();
      s_sleep();
      s_restart();
      print_verdict();
   end
endmodule : tb_top
